// *** half_move_unit.sv ***
// half-precision move, box, compare and classify datapath slice
`timescale 1ns/1ps
`default_nettype none
module half_move_unit
    import half_move_pkg::*;
#(
    parameter int INTEGER_REGISTER_WIDTH = INTEGER_REGISTER_WIDTH_DEF,
    parameter int FLEN = FLEN_DEF,
    parameter bit HAS_SINGLE = 1'b1,
    parameter bit HAS_DOUBLE = 1'b1,
    parameter bit HAS_QUAD = 1'b0,
    parameter bit MIN_ONLY = 1'b1
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic valid_i,
    input wire half_op_t op_i,
    input wire logic [FLEN-1:0] fp_a_i,
    input wire logic [FLEN-1:0] fp_b_i,
    input wire logic [INTEGER_REGISTER_WIDTH-1:0] int_a_i,
    input wire logic [HALF_W-1:0] load_data_i,
    input wire logic cvt_to_quad_i,
    output logic valid_o,
    output logic [INTEGER_REGISTER_WIDTH-1:0] int_res_o,
    output logic int_we_o,
    output logic [FLEN-1:0] fp_res_o,
    output logic fp_we_o,
    output logic [HALF_W-1:0] store_data_o,
    output logic store_we_o,
    output fflags_t flags_o,
    output logic illegal_o,
    output logic cvt_pass_o
);
    // single-precision support is a prerequisite, checked at elaboration
    if (!HAS_SINGLE) begin : g_need_single
        $error("half support requires single precision");
    end

    // a register must be properly boxed to hold a half operand
    function automatic logic [HALF_W-1:0] unbox(input logic [FLEN-1:0] r);
        unbox = (&r[FLEN-1:HALF_W]) ? r[HALF_W-1:0] : 16'h7E00;
    endfunction

    function automatic logic [FLEN-1:0] box(input logic [HALF_W-1:0] h);
        box = {{(FLEN-HALF_W){1'b1}}, h};
    endfunction

    function automatic logic is_nan(input logic [HALF_W-1:0] h);
        is_nan = (h[14:10] == EXP_ONES) && (h[9:0] != 10'h000);
    endfunction

    function automatic logic is_snan(input logic [HALF_W-1:0] h);
        is_snan = is_nan(h) && !h[9];
    endfunction

    // strict less-than on ordered operands, zeros of either sign equal
    function automatic logic flt(input logic [HALF_W-1:0] a, input logic [HALF_W-1:0] b);
        logic both_zero;
        both_zero = (a[14:0] == 15'h0000) && (b[14:0] == 15'h0000);
        if (both_zero)
            flt = 1'b0;
        else if (a[15] != b[15])
            flt = a[15];
        else if (a[15])
            flt = a[14:0] > b[14:0];
        else
            flt = a[14:0] < b[14:0];
    endfunction

    // ten-bit category mask in single-precision order
    function automatic logic [9:0] classify(input logic [HALF_W-1:0] h);
        logic e0;
        logic e1;
        logic m0;
        e0 = h[14:10] == 5'h00;
        e1 = h[14:10] == EXP_ONES;
        m0 = h[9:0] == 10'h000;
        classify = {e1 && !m0 && h[9], e1 && !m0 && !h[9],
                    !h[15] && e1 && m0, !h[15] && !e0 && !e1,
                    !h[15] && e0 && !m0, !h[15] && e0 && m0,
                    h[15] && e0 && m0, h[15] && e0 && !m0,
                    h[15] && !e0 && !e1, h[15] && e1 && m0};
    endfunction

    logic [HALF_W-1:0] ha;
    logic [HALF_W-1:0] hb;
    logic any_nan;
    logic any_snan;
    logic op_ok;
    assign ha = unbox(fp_a_i);
    assign hb = unbox(fp_b_i);
    assign any_nan = is_nan(ha) || is_nan(hb);
    assign any_snan = is_snan(ha) || is_snan(hb);

    // which operations this configuration accepts
    always_comb
    begin
        unique case (op_i)
            OP_MV_F2I, OP_MV_I2F, OP_LOAD, OP_STORE: op_ok = 1'b1;
            OP_CVT_SD: op_ok = 1'b1;
            OP_CVT_Q: op_ok = HAS_QUAD;
            OP_SGNJ: op_ok = !MIN_ONLY;
            OP_CMP_EQ, OP_CMP_LT, OP_CMP_LE, OP_CLASS, OP_ARITH: op_ok = !MIN_ONLY;
            default: op_ok = 1'b0;
        endcase
    end

    // integer-side results: moves, compares, classify
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            int_res_o <= '0;
            int_we_o <= 1'b0;
            flags_o <= '0;
        end
        else
        begin
            int_we_o <= 1'b0;
            flags_o <= '0;
            if (valid_i && op_ok)
            begin
                unique case (op_i)
                    OP_MV_F2I:
                    begin
                        // raw bits from the register, no unboxing or canonicalising
                        int_res_o <= {{(INTEGER_REGISTER_WIDTH-HALF_W){fp_a_i[15]}}, fp_a_i[15:0]};
                        int_we_o <= 1'b1;
                    end
                    OP_CMP_EQ:
                    begin
                        int_res_o <= INTEGER_REGISTER_WIDTH'(!any_nan && (ha == hb || (!flt(ha, hb)
                            && !flt(hb, ha))));
                        int_we_o <= 1'b1;
                        flags_o.invalid <= any_snan;
                    end
                    OP_CMP_LT, OP_CMP_LE:
                    begin
                        // signalling compares: any NaN is invalid
                        int_res_o <= INTEGER_REGISTER_WIDTH'(!any_nan && (flt(ha, hb) || (op_i == OP_CMP_LE
                            && !flt(hb, ha))));
                        int_we_o <= 1'b1;
                        flags_o.invalid <= any_nan;
                    end
                    OP_CLASS:
                    begin
                        int_res_o <= INTEGER_REGISTER_WIDTH'(classify(ha));
                        int_we_o <= 1'b1;
                    end
                    default:
                    begin
                        int_we_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    // float-side results: boxed moves and loads
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fp_res_o <= '0;
            fp_we_o <= 1'b0;
        end
        else
        begin
            fp_we_o <= valid_i && op_ok && (op_i == OP_MV_I2F || op_i == OP_LOAD);
            if (valid_i && op_ok && op_i == OP_MV_I2F)
                fp_res_o <= box(int_a_i[HALF_W-1:0]);
            else if (valid_i && op_ok && op_i == OP_LOAD)
                fp_res_o <= box(load_data_i);
        end
    end

    // store path drops everything above the half
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            store_data_o <= '0;
            store_we_o <= 1'b0;
        end
        else
        begin
            store_we_o <= valid_i && op_ok && op_i == OP_STORE;
            if (valid_i && op_i == OP_STORE)
                store_data_o <= fp_a_i[HALF_W-1:0];
        end
    end

    // completion, trap and hand-off of converts to the conversion unit
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            valid_o <= 1'b0;
            illegal_o <= 1'b0;
            cvt_pass_o <= 1'b0;
        end
        else
        begin
            valid_o <= valid_i;
            illegal_o <= valid_i && !op_ok;
            cvt_pass_o <= valid_i && op_ok && (op_i == OP_CVT_SD || op_i == OP_CVT_Q);
        end
    end

    property p_f2i_sext;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (valid_i && op_i == OP_MV_F2I) |=> int_we_o
            && int_res_o == {{(INTEGER_REGISTER_WIDTH-HALF_W){$past(fp_a_i[15])}}, $past(fp_a_i[15:0])};
    endproperty
    a_f2i_sext: assert property (p_f2i_sext) else $error("float-to-int move wrong");

    property p_i2f_box;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (valid_i && op_i == OP_MV_I2F) |=> fp_we_o && &fp_res_o[FLEN-1:HALF_W];
    endproperty
    a_i2f_box: assert property (p_i2f_box) else $error("int-to-float not boxed");

    property p_i2f_bits;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (valid_i && op_i == OP_MV_I2F) |=> fp_res_o[15:0] == $past(int_a_i[15:0]);
    endproperty
    a_i2f_bits: assert property (p_i2f_bits) else $error("moved bits altered");

    property p_load_box;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (valid_i && op_i == OP_LOAD) |=> fp_res_o == box($past(load_data_i));
    endproperty
    a_load_box: assert property (p_load_box) else $error("load not boxed");

    sequence s_store_req;
        valid_i && op_i == OP_STORE;
    endsequence
    property p_store_low;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        s_store_req |=> store_we_o && store_data_o == $past(fp_a_i[15:0]);
    endproperty
    a_store_low: assert property (p_store_low) else $error("store data wrong");

    property p_cmp_nan;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (valid_i && !MIN_ONLY && op_i == OP_CMP_LT && any_nan) |=> int_res_o == '0
            && flags_o.invalid;
    endproperty
    a_cmp_nan: assert property (p_cmp_nan) else $error("compare NaN handling wrong");

    property p_class_onehot;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (valid_i && !MIN_ONLY && op_i == OP_CLASS) |=> $onehot(int_res_o[9:0]);
    endproperty
    a_class_onehot: assert property (p_class_onehot) else $error("classify not one-hot");

    property p_min_trap;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (valid_i && MIN_ONLY && (op_i == OP_SGNJ || op_i == OP_ARITH)) |=> illegal_o
            && !int_we_o && !fp_we_o;
    endproperty
    a_min_trap: assert property (p_min_trap) else $error("excluded op not trapped");

    property p_sgnj_min;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (valid_i && op_i == OP_SGNJ) |=> illegal_o == MIN_ONLY;
    endproperty
    a_sgnj_min: assert property (p_sgnj_min) else $error("sign inject gating wrong");

    property p_cvt_pass;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (valid_i && op_i == OP_CVT_SD) |=> cvt_pass_o && !illegal_o;
    endproperty
    a_cvt_pass: assert property (p_cvt_pass) else $error("convert not accepted");

    property p_quad_gate;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (valid_i && op_i == OP_CVT_Q) |=> cvt_pass_o == HAS_QUAD;
    endproperty
    a_quad_gate: assert property (p_quad_gate) else $error("quad convert gating wrong");
endmodule
`default_nettype wire

// *** half_move_pkg.sv ***
// constants and types for the half-precision move and compare slice
package half_move_pkg;
    localparam int HALF_W = 16;
    localparam int FLEN_DEF = 64;
    localparam int INTEGER_REGISTER_WIDTH_DEF = 64;
    localparam logic [4:0] EXP_ONES = 5'h1F;
    localparam logic [9:0] QUIET_BIT = 10'h200;
    // one-hot operation codes plus the all-zero empty code, as presented by decode
    typedef enum logic [11:0] {
        OP_NONE = 12'h000,
        OP_MV_F2I = 12'h001,
        OP_MV_I2F = 12'h002,
        OP_LOAD = 12'h004,
        OP_STORE = 12'h008,
        OP_CMP_EQ = 12'h010,
        OP_CMP_LT = 12'h020,
        OP_CMP_LE = 12'h040,
        OP_CLASS = 12'h080,
        OP_SGNJ = 12'h100,
        OP_ARITH = 12'h200,
        OP_CVT_SD = 12'h400,
        OP_CVT_Q = 12'h800
    } half_op_t;
    // exception flag bits, single-precision style
    typedef struct packed {
        logic invalid;
        logic div_zero;
        logic overflow;
        logic underflow;
        logic inexact;
    } fflags_t;
endpackage

// *** pipe_mem_model.sv ***
// memory side of the pipeline: returns a fresh half value every cycle
`timescale 1ns/1ps
`default_nettype none
module pipe_mem_model
#(
    parameter logic [15:0] LOAD_SEED = 16'hace1
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    output logic [15:0] load_data_o
);
    // lfsr pattern, so a stale or early sampled load word shows up as wrong data
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            load_data_o <= LOAD_SEED;
        else
            load_data_o <= {load_data_o[14:0], load_data_o[15] ^ load_data_o[13] ^
                            load_data_o[12] ^ load_data_o[10]};
    end
endmodule
`default_nettype wire

// *** half_move_unit_tb.sv ***
// self-checking bench for the half move slice, minimal and full configurations side by side
`timescale 1ns/1ps
`default_nettype none
module half_move_unit_tb;
    import half_move_pkg::*;
    typedef struct packed {
        logic [4:0] we;
        logic [4:0] we2;
        logic [1:0] kn;
        logic [4:0] fl2;
        logic [63:0] ires;
        logic [63:0] ires2;
        logic [63:0] fres;
        logic [15:0] sdat;
    } exp_t;
    logic clk_sys_i = 1'b0;
    logic rst_n_i;
    logic valid_i;
    half_op_t op_i;
    logic [63:0] fp_a_i, fp_b_i, int_a_i;
    logic [15:0] load_data_i, store_data_o;
    logic cvt_to_quad_i, valid_o, int_we_o, fp_we_o, store_we_o, illegal_o, cvt_pass_o;
    logic [63:0] int_res_o, fp_res_o;
    fflags_t flags_o;
    // outputs of the full slice, which sees the very same op stream
    logic full_valid, full_iwe, full_fwe, full_swe, full_ill, full_cvt;
    logic [63:0] full_ires, full_fres;
    logic [15:0] full_sdat;
    fflags_t full_flags;
    // hand-worked operand and answer for the next op, when known_case is set
    logic known_case = 1'b0;
    logic [63:0] case_b = 64'h0;
    logic [9:0] case_res = 10'h000;
    logic [4:0] case_fl = 5'h00;
    localparam logic [47:0] BOX = 48'hffff_ffff_ffff;
    exp_t expq[$];
    exp_t e;
    int failures = 0;
    int n_compared = 0;
    int seed;
    logic [15:0] corner[6] = '{16'h7c01, 16'h7d55, 16'h7e00, 16'h8000, 16'hffff, 16'h0001};

    // 40 MHz
    always #12.5 clk_sys_i = ~clk_sys_i;

    half_move_unit #(.INTEGER_REGISTER_WIDTH(64), .FLEN(64), .HAS_QUAD(1'b0), .MIN_ONLY(1'b1)) u_half_move_unit (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .valid_i(valid_i), .op_i(op_i),
        .fp_a_i(fp_a_i), .fp_b_i(fp_b_i), .int_a_i(int_a_i), .load_data_i(load_data_i),
        .cvt_to_quad_i(cvt_to_quad_i), .valid_o(valid_o), .int_res_o(int_res_o),
        .int_we_o(int_we_o), .fp_res_o(fp_res_o), .fp_we_o(fp_we_o),
        .store_data_o(store_data_o), .store_we_o(store_we_o), .flags_o(flags_o),
        .illegal_o(illegal_o), .cvt_pass_o(cvt_pass_o));

    pipe_mem_model u_pipe_mem_model (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .load_data_o(load_data_i));

    // full slice with quad support, so compare, classify and quad paths are reached
    half_move_unit #(.INTEGER_REGISTER_WIDTH(64), .FLEN(64), .HAS_QUAD(1'b1), .MIN_ONLY(1'b0))
        u_half_move_unit_full (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .valid_i(valid_i), .op_i(op_i),
        .fp_a_i(fp_a_i), .fp_b_i(fp_b_i), .int_a_i(int_a_i), .load_data_i(load_data_i),
        .cvt_to_quad_i(cvt_to_quad_i), .valid_o(full_valid), .int_res_o(full_ires),
        .int_we_o(full_iwe), .fp_res_o(full_fres), .fp_we_o(full_fwe),
        .store_data_o(full_sdat), .store_we_o(full_swe), .flags_o(full_flags),
        .illegal_o(full_ill), .cvt_pass_o(full_cvt));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("failures=%0d n_compared=%0d", failures, n_compared);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // drive one op at the falling edge and note what both slices must return
    task automatic send(input half_op_t o, input logic [63:0] a, input logic [63:0] i);
        exp_t x;
        logic cmp;
        @(negedge clk_sys_i);
        valid_i = 1'b1;
        op_i = o;
        fp_a_i = a;
        fp_b_i = known_case ? case_b : {$random(seed), $random(seed)};
        int_a_i = i;
        cmp = o == OP_CMP_EQ || o == OP_CMP_LT || o == OP_CMP_LE;
        // minimal slice traps the empty code and everything outside its subset
        x.we = {o == OP_MV_F2I, o == OP_MV_I2F || o == OP_LOAD, o == OP_STORE,
                o == OP_NONE || cmp || o == OP_CLASS || o == OP_SGNJ || o == OP_ARITH ||
                o == OP_CVT_Q, o == OP_CVT_SD};
        // full slice with quad takes every real code, only the empty code traps
        x.we2 = {o == OP_MV_F2I || cmp || o == OP_CLASS, x.we[3:2], o == OP_NONE,
                 o == OP_CVT_SD || o == OP_CVT_Q};
        // random compares have no worked answer, so only known ones are compared
        x.kn = {known_case || o == OP_MV_F2I, known_case || !cmp};
        x.fl2 = known_case ? case_fl : 5'h00;
        x.ires = {{48{a[15]}}, a[15:0]};
        x.ires2 = known_case ? {54'h0, case_res} : x.ires;
        x.fres = {48'hffff_ffff_ffff, (o == OP_LOAD) ? load_data_i : i[15:0]};
        x.sdat = a[15:0];
        expq.push_back(x);
    endtask

    // a compare or classify whose answer was worked out by hand
    task automatic cmp_case(input half_op_t o, input logic [63:0] a, input logic [63:0] b,
                            input logic [9:0] r, input logic [4:0] fl);
        known_case = 1'b1;
        case_b = b;
        case_res = r;
        case_fl = fl;
        send(o, a, 64'h0);
        known_case = 1'b0;
    endtask

    // results are registered, so they are settled by the falling edge
    always @(negedge clk_sys_i)
    begin
        if (valid_o === 1'b1)
        begin
            if (expq.size() == 0)
                check(64'h1, 64'h0);
            else
            begin
                e = expq.pop_front();
                check({int_we_o, fp_we_o, store_we_o, illegal_o, cvt_pass_o}, e.we);
                check(flags_o, 64'h0);
                if (e.we[4])
                    check(int_res_o, e.ires);
                if (e.we[3])
                    check(fp_res_o, e.fres);
                if (e.we[2])
                    check(store_data_o, e.sdat);
                // full slice answers in the same cycle
                check(full_valid, 64'h1);
                check({full_iwe, full_fwe, full_swe, full_ill, full_cvt}, e.we2);
                if (e.kn[0])
                    check(full_flags, e.fl2);
                if (e.we2[4] && e.kn[1])
                    check(full_ires, e.ires2);
                if (e.we2[3])
                    check(full_fres, e.fres);
                if (e.we2[2])
                    check(full_sdat, e.sdat);
            end
        end
    end

    // main sequence: corner halves through both moves, then every op back to back
    initial
    begin
        seed = 32'h5406e856;
        rst_n_i = 1'b0;
        valid_i = 1'b0;
        op_i = OP_NONE;
        fp_a_i = '0;
        fp_b_i = '0;
        int_a_i = '0;
        cvt_to_quad_i = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        check({valid_o, int_we_o, fp_we_o, store_we_o, illegal_o, cvt_pass_o}, 64'h0);
        check({full_valid, full_iwe, full_fwe, full_swe, full_ill, full_cvt}, 64'h0);
        // nan payloads and sign edges must survive both directions untouched
        foreach (corner[k])
        begin
            send(OP_MV_F2I, {48'h1234_5678_9abc, corner[k]}, 64'h0);
            send(OP_MV_I2F, 64'h0, {$random(seed), $random(seed)} & 64'hffff_ffff_ffff_0000 |
                 {48'h0, corner[k]});
            send(OP_STORE, {$random(seed), 16'h0, corner[k]}, 64'h0);
            send(OP_LOAD, 64'h0, 64'h0);
        end
        send(OP_NONE, 64'h0, 64'h0);
        // every one-hot code, refused ones included, with random operands
        repeat (4)
        begin
            for (int k = 0; k < 12; k++)
                send(half_op_t'(12'h001 << k), {$random(seed), $random(seed)},
                     {$random(seed), $random(seed)});
        end
        // worked compares: signed zeros, nan flavours, improper boxing, ordering
        cmp_case(OP_CMP_EQ, {BOX, 16'h3c00}, {BOX, 16'h3c00}, 10'h001, 5'h00);
        cmp_case(OP_CMP_EQ, {BOX, 16'h0000}, {BOX, 16'h8000}, 10'h001, 5'h00);
        cmp_case(OP_CMP_EQ, {BOX, 16'h7c01}, {BOX, 16'h3c00}, 10'h000, 5'h10);
        cmp_case(OP_CMP_EQ, {BOX, 16'h7e00}, {BOX, 16'h7e00}, 10'h000, 5'h00);
        cmp_case(OP_CMP_LT, {BOX, 16'hbc00}, {BOX, 16'h3c00}, 10'h001, 5'h00);
        cmp_case(OP_CMP_LT, {BOX, 16'h3c00}, {BOX, 16'h3c00}, 10'h000, 5'h00);
        cmp_case(OP_CMP_LT, {BOX, 16'h7e00}, {BOX, 16'h3c00}, 10'h000, 5'h10);
        cmp_case(OP_CMP_LT, 64'h0000_0000_0000_3c00, {BOX, 16'h3c00}, 10'h000, 5'h10);
        cmp_case(OP_CMP_LE, {BOX, 16'h3c00}, {BOX, 16'h3c00}, 10'h001, 5'h00);
        cmp_case(OP_CMP_LE, {BOX, 16'h4000}, {BOX, 16'h3c00}, 10'h000, 5'h00);
        cmp_case(OP_CMP_LE, {BOX, 16'hfc00}, {BOX, 16'hbc00}, 10'h001, 5'h00);
        // worked classifies, one per category reached, plus an unboxed operand
        cmp_case(OP_CLASS, {BOX, 16'h3c00}, 64'h0, 10'h040, 5'h00);
        cmp_case(OP_CLASS, {BOX, 16'hfc00}, 64'h0, 10'h001, 5'h00);
        cmp_case(OP_CLASS, {BOX, 16'h7e00}, 64'h0, 10'h200, 5'h00);
        cmp_case(OP_CLASS, {BOX, 16'h7c01}, 64'h0, 10'h100, 5'h00);
        cmp_case(OP_CLASS, {BOX, 16'h8000}, 64'h0, 10'h008, 5'h00);
        cmp_case(OP_CLASS, {BOX, 16'h0001}, 64'h0, 10'h020, 5'h00);
        cmp_case(OP_CLASS, 64'h0000_0000_0000_3c00, 64'h0, 10'h200, 5'h00);
        @(negedge clk_sys_i);
        valid_i = 1'b0;
        op_i = OP_NONE;
        for (int k = 0; k < 20 && expq.size() > 0; k++)
            @(negedge clk_sys_i);
        if (expq.size() > 0)
            failures++;
        end_of_test();
    end
endmodule
`default_nettype wire
